/* inc/ccs_map.svh */
// constants of the clock source select block: timing and reset values
// assumes the system clock runs at the rate given by CCS_CLK_MHZ
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH

`define CCS_CLK_MHZ 250
// internal oscillator divide ratio, 250 MHz / 16 = 15.625 MHz core rate
`define CCS_INT_DIV 16
// slowest usable reference is 8 MHz (125 ns); two missing periods mean loss
`define CCS_LOSS_TIME_NS 250
`define CCS_LOSS_CYC ((`CCS_LOSS_TIME_NS * `CCS_CLK_MHZ) / 1000)
`define CCS_RST_SRC_EXT 1'b0
`define CCS_RST_FAULT 1'b0

`endif

/* inc/ccs_pkg.sv */
// types of the clock source select block
// used by the top module and shared with the bench through its ports
package ccs_pkg;

typedef enum logic [1:0] {
    CCS_ST_INT,
    CCS_ST_ARM,
    CCS_ST_EXT,
    CCS_ST_LOST
} ccs_state_e;

typedef struct packed {
    logic src_ext;
    logic clk_lost;
    logic core_run;
} ccs_status_s;

endpackage : ccs_pkg

/* verilog/ccs_osc_div.sv */
// stand-in for the on-chip oscillator: a divider giving one-cycle ticks
// assumes a single free-running clock and a synchronous active-low reset copy
`timescale 1ns/1ps
module ccs_osc_div #(
    parameter int DIV = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    output logic tick
);

localparam int CW = (DIV > 2) ? $clog2(DIV) : 1;
localparam logic [CW-1:0] LAST = CW'(DIV - 1);

logic [CW-1:0] cnt_ff;
logic [CW-1:0] nxt_cnt;
logic tick_ff;
logic nxt_tick;

generate
    if (DIV < 2)
    begin : g_bad_div
        $error("ccs_osc_div: DIV must be at least 2");
    end
endgenerate

always_comb
begin
    nxt_tick = (cnt_ff == LAST);
    nxt_cnt = nxt_tick ? '0 : cnt_ff + CW'(1);
end

always_ff @(posedge clk or negedge rst_n)
begin
    if (!rst_n)
    begin
        cnt_ff <= '0;
        tick_ff <= 1'b0;
    end
    else
    begin
        cnt_ff <= nxt_cnt;
        tick_ff <= nxt_tick;
    end
end

assign tick = tick_ff;

endmodule : ccs_osc_div

/* verilog/ccs_clk_select.sv */
// clock source select: internal oscillator until the reference pin first goes
// high, then the reference; halts the core on reference loss; short detect
// stays alive throughout.
// assumes clk_pin and the sense inputs are synchronous to clk.
// Contract
// [R1] all core timing follows one selected tick
// [R2] pin held low keeps internal oscillator
// [R3] first high on pin selects external
// [R4] lost reference halts core and chopper
// [R5] short detection independent of selected clock
// [R6] host disables drivers before stopping clock
// [R7] host calibrates internal oscillator by positions
// [R8] reference 10-16 MHz, 18 max, 8 min
// [R9] source takeover without truncated or doubled tick
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_clk_select #(
    parameter int INT_DIV = `CCS_INT_DIV,
    parameter int LOSS_CYC = `CCS_LOSS_CYC
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_pin,
    input wire logic s2g_en,
    input wire logic s2g_sense,
    output logic core_tick,
    output ccs_pkg::ccs_status_s status,
    output logic s2g_fault
);

localparam int LW = $clog2(LOSS_CYC + 1);
localparam logic [LW-1:0] LOSS_LAST = LW'(LOSS_CYC);

generate
    if (LOSS_CYC < 2)
    begin : g_bad_loss
        $error("ccs_clk_select: LOSS_CYC must be at least 2");
    end
endgenerate

logic rst_meta_ff;
logic rst_n_ff;
logic int_tick;
logic pin_q_ff;
logic pin_rise;
ccs_pkg::ccs_state_e state_ff;
ccs_pkg::ccs_state_e nxt_state;
logic [LW-1:0] idle_ff;
logic [LW-1:0] nxt_idle;
logic tick_ff;
logic nxt_tick;
logic fault_ff;
logic nxt_fault;

// reset released through two flops
always_ff @(posedge clk or negedge rstn)
begin
    if (!rstn)
    begin
        rst_meta_ff <= 1'b0;
        rst_n_ff <= 1'b0;
    end
    else
    begin
        rst_meta_ff <= 1'b1;
        rst_n_ff <= rst_meta_ff;
    end
end

ccs_osc_div #(
    .DIV(INT_DIV)
) u_osc (
    .clk(clk),
    .rst_n(rst_n_ff),
    .tick(int_tick)
);

assign pin_rise = clk_pin & ~pin_q_ff;

always_comb
begin
    nxt_state = state_ff;
    nxt_tick = 1'b0;
    nxt_idle = idle_ff;
    case (state_ff)
        ccs_pkg::CCS_ST_INT:
        begin
            nxt_tick = int_tick; // R2
            if (clk_pin)
            begin
                nxt_state = ccs_pkg::CCS_ST_ARM; // R3
            end
        end
        ccs_pkg::CCS_ST_ARM:
        begin
            // finish the running internal period so no tick is cut short
            nxt_tick = int_tick; // R9
            nxt_idle = '0;
            if (int_tick)
            begin
                nxt_state = ccs_pkg::CCS_ST_EXT; // R9
            end
        end
        ccs_pkg::CCS_ST_EXT:
        begin
            // the rise that armed takeover is not replayed as a tick
            nxt_tick = pin_rise; // R1
            if (pin_rise)
            begin
                nxt_idle = '0;
            end
            else if (idle_ff == LOSS_LAST)
            begin
                nxt_state = ccs_pkg::CCS_ST_LOST; // R4
            end
            else
            begin
                nxt_idle = idle_ff + LW'(1);
            end
        end
        ccs_pkg::CCS_ST_LOST:
        begin
            // no fallback to the oscillator: the takeover is one-way
            nxt_tick = 1'b0; // R4
            if (pin_rise)
            begin
                nxt_state = ccs_pkg::CCS_ST_EXT;
                nxt_tick = 1'b1;
                nxt_idle = '0;
            end
        end
        default:
        begin
            nxt_state = ccs_pkg::CCS_ST_INT;
        end
    endcase
end

always_ff @(posedge clk or negedge rst_n_ff)
begin
    if (!rst_n_ff)
    begin
        state_ff <= ccs_pkg::CCS_ST_INT;
        pin_q_ff <= 1'b0;
        idle_ff <= '0;
        tick_ff <= 1'b0;
    end
    else
    begin
        state_ff <= nxt_state;
        pin_q_ff <= clk_pin;
        idle_ff <= nxt_idle;
        tick_ff <= nxt_tick;
    end
end

// short detection sees the raw system clock, never the selected tick
always_comb
begin
    nxt_fault = fault_ff;
    if (s2g_en && s2g_sense)
    begin
        nxt_fault = 1'b1; // R5
    end
    else if (!s2g_en)
    begin
        nxt_fault = 1'b0;
    end
end

always_ff @(posedge clk or negedge rst_n_ff)
begin
    if (!rst_n_ff)
    begin
        fault_ff <= `CCS_RST_FAULT;
    end
    else
    begin
        fault_ff <= nxt_fault;
    end
end

assign core_tick = tick_ff;
assign s2g_fault = fault_ff;
// one driver for the whole packed status word
assign status = '{
    src_ext: (state_ff == ccs_pkg::CCS_ST_EXT) || (state_ff == ccs_pkg::CCS_ST_LOST),
    clk_lost: (state_ff == ccs_pkg::CCS_ST_LOST),
    core_run: (state_ff != ccs_pkg::CCS_ST_LOST) // R4
};

endmodule : ccs_clk_select

/* tb/ccs_clk_chk.sv */
// assertions on the ports of the clock source select block
// assumes the bind hands over the bound instance's INT_DIV and LOSS_CYC
`timescale 1ns/1ps
module ccs_clk_chk #(
    parameter int INT_DIV = 16,
    parameter int LOSS_CYC = 62
) (
    input wire logic clk,
    input wire logic rstn,
    input wire logic clk_pin,
    input wire logic s2g_en,
    input wire logic s2g_sense,
    input wire logic core_tick,
    input wire ccs_pkg::ccs_status_s status,
    input wire logic s2g_fault
);
    logic seen_ff;
    logic nxt_seen;
    logic pin_q_ff;
    logic ext_rise;
    logic [15:0] gap_ff;
    logic [15:0] nxt_gap;
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    // cycles since the last reference rise; the loss window is far too long to unroll
    assign ext_rise = clk_pin & ~pin_q_ff;
    always_comb
    begin
        nxt_seen = seen_ff | clk_pin;
        nxt_gap = gap_ff;
        if (!status.src_ext || ext_rise)
            nxt_gap = '0;
        else if (gap_ff != 16'hffff)
            nxt_gap = gap_ff + 16'h0001;
    end
    always_ff @(posedge clk or negedge rstn)
        if (!rstn)
        begin
            seen_ff <= 1'b0;
            pin_q_ff <= 1'b0;
            gap_ff <= '0;
        end
        else
        begin
            seen_ff <= nxt_seen;
            pin_q_ff <= clk_pin;
            gap_ff <= nxt_gap;
        end
    tick_period_a: assert property (
        core_tick && !status.src_ext |-> ##INT_DIV core_tick) else $error("internal period");
    int_hold_a: assert property (
        !seen_ff |-> !status.src_ext) else $error("external without pin high");
    ext_tick_a: assert property (
        status.src_ext && $rose(clk_pin) |=> core_tick) else $error("reference rise lost");
    switch_tick_a: assert property (
        $rose(status.src_ext) |-> core_tick) else $error("switch off tick boundary");
    loss_set_a: assert property (
        status.src_ext && !status.clk_lost && !ext_rise && gap_ff == 16'(LOSS_CYC)
        |=> status.clk_lost) else $error("loss not flagged");
    loss_early_a: assert property (
        gap_ff < 16'(LOSS_CYC) |=> !status.clk_lost) else $error("loss flagged early");
    lost_halt_a: assert property (
        status.clk_lost |-> !status.core_run && !core_tick) else $error("core runs while lost");
    fault_set_a: assert property (
        s2g_en && s2g_sense |=> s2g_fault) else $error("short not flagged");
    fault_clr_a: assert property (
        !s2g_en |=> !s2g_fault) else $error("short not cleared");
endmodule : ccs_clk_chk
bind ccs_clk_select ccs_clk_chk #(.INT_DIV(INT_DIV), .LOSS_CYC(LOSS_CYC)) i_chk (
    .clk(clk), .rstn(rstn), .clk_pin(clk_pin), .s2g_en(s2g_en), .s2g_sense(s2g_sense),
    .core_tick(core_tick), .status(status), .s2g_fault(s2g_fault));

/* tb/ccs_ref_osc.sv */
// model of the external reference oscillator on the clock pin
// assumes the bench clock; half period counted in bench cycles
`timescale 1ns/1ps
module ccs_ref_osc (
    input wire logic clk,
    input wire logic run,
    input wire logic [3:0] half,
    output logic pin
);
    logic [3:0] cnt;
    initial pin = 1'b0;
    initial cnt = 4'h0;
    always @(posedge clk)
    begin
        cnt <= (!run || cnt + 4'h1 >= half) ? 4'h0 : cnt + 4'h1;
        if (!run)
            pin <= 1'b0;
        else if (cnt + 4'h1 >= half)
            pin <= ~pin;
    end
endmodule : ccs_ref_osc

/* tb/testbench.sv */
// self-checking bench of the clock source select block
// assumes INT_DIV 4, LOSS_CYC 62 and a 20-cycle reference period (12.5 MHz)
`timescale 1ns/1ps
`define CHK(a, e) begin n_compared++; if ((a) !== (e)) begin failures++; \
    $display("[FAIL] %0t %h %h", $time, (a), (e)); end end
module testbench;
    logic clk, rstn, run, s2g_en, s2g_sense, clk_pin, core_tick, s2g_fault;
    ccs_pkg::ccs_status_s status;
    int failures = 0;
    int n_compared = 0;
    logic [15:0] k;
    // a reference inside the recommended band keeps each half period below the loss window
    ccs_ref_osc i_osc (.clk(clk), .run(run), .half(4'ha), .pin(clk_pin));
    ccs_clk_select #(.INT_DIV(4), .LOSS_CYC(62)) i_dut (.clk(clk), .rstn(rstn),
        .clk_pin(clk_pin), .s2g_en(s2g_en), .s2g_sense(s2g_sense),
        .core_tick(core_tick), .status(status), .s2g_fault(s2g_fault));
    task automatic ticks(input int n);
        k = '0;
        repeat (n)
        begin
            @(posedge clk);
            #1;
            k = k + {15'h0000, core_tick};
        end
    endtask : ticks
    task automatic stop_test;
        if (failures == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic t_takeover;
        // ticks counted against the bench clock, as a host calibrates by positions
        ticks(40);
        `CHK(k, 16'h000a)
        `CHK(status.src_ext, 1'b0)
        @(posedge clk);
        run <= 1'b1;
        // window spans the switch: four whole internal periods, none cut or doubled
        ticks(16);
        `CHK(k, 16'h0004)
        `CHK(status.src_ext, 1'b1)
        ticks(60);
        `CHK(k, 16'h0003)
    endtask : t_takeover
    task automatic t_loss_short;
        // no driver enable on this block: a host would switch the drivers off first
        @(posedge clk);
        run <= 1'b0;
        ticks(60);
        `CHK(status.clk_lost, 1'b1)
        `CHK(status.core_run, 1'b0)
        ticks(10);
        `CHK(k, 16'h0000)
        @(posedge clk);
        s2g_en <= 1'b1;
        s2g_sense <= 1'b1;
        ticks(2);
        `CHK(s2g_fault, 1'b1)
        @(posedge clk);
        s2g_en <= 1'b0;
        ticks(2);
        `CHK(s2g_fault, 1'b0)
        @(posedge clk);
        run <= 1'b1;
        ticks(20);
        `CHK(status.clk_lost, 1'b0)
        `CHK(k, 16'h0001)
        `CHK(status.src_ext, 1'b1)
    endtask : t_loss_short
    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial
    begin
        {rstn, run, s2g_en, s2g_sense} = 4'h0;
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        repeat (12) @(posedge clk);
        t_takeover();
        t_loss_short();
        stop_test();
    end
endmodule : testbench
